// File: pdc_pkg.sv
// Purpose: Shared constants and types for the port descriptor control block
// Assumes: 32-bit AHB-Lite register bus, 16-bit descriptor word
// Notes: Register offsets are byte addresses
`default_nettype none
package pdc_pkg;
	// ---------------------------------------------
	// Register map
	// ---------------------------------------------
	localparam logic [7:0] OFS_DESCRIPTOR = 8'h00;
	localparam logic [7:0] OFS_CONTROL = 8'h04;
	localparam logic [7:0] OFS_EVENTS = 8'h08;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h0c;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
	localparam logic [7:0] OFS_REPORT = 8'h14;
	localparam logic [15:0] RST_DESCRIPTOR = 16'h0000;
	localparam logic [1:0] RST_CONTROL = 2'h0;
	localparam logic [6:0] RST_IRQ_MASK = 7'h00;
	// ---------------------------------------------
	// Field positions
	// ---------------------------------------------
	localparam int CTL_BIG_ENDIAN = 0;
	localparam int CTL_EXT_DIAG = 1;
	localparam logic [2:0] SEL_NONE = 3'h0;
	localparam logic [2:0] SEL_SIX = 3'h6;
	localparam logic [2:0] SEL_SEVEN = 3'h7;
	// ---------------------------------------------
	// Types
	// ---------------------------------------------
	typedef struct packed {
		logic [4:0] spare;
		logic write_always;
		logic source_flag;
		logic sink;
		logic [1:0] clear_pending_event;
		logic queue_attach;
		logic numeric;
		logic force_enable;
		logic [2:0] interrupt_select;
	} pdc_desc_s;
	typedef struct packed {
		logic done;
		logic ok;
		logic recoverable;
	} pdc_xfer_s;
	typedef enum logic [1:0] {
		Q_AREA = 2'b00,
		Q_RX = 2'b01,
		Q_TX0 = 2'b10,
		Q_TX1 = 2'b11
	} pdc_queue_e;
	typedef enum logic [1:0] {
		W_IDLE = 2'b00,
		W_MASK = 2'b01,
		W_DATA = 2'b10,
		W_EMIT = 2'b11
	} pdc_word_e;
endpackage : pdc_pkg
`default_nettype wire

// File: pdc_port_ctrl.sv
// Purpose: Port descriptor control logic with AHB-Lite register access
// Assumes: Transfer, queue, line and memory inputs come from hclk logic
// Notes: Contract
// Contract
// - Select codes one to five raise interrupts
// - Interrupt only on success or recoverable data
// - Select six raises interrupt six
// - Select seven: sink compares, source silent
// - Clear pending event on any transfer
// - Queue attached: clear only when empty; event parameter clears regardless
// - Sink uses receive queue, source transmit
// - No queue: use port data area
// - Numeric flag selects bus byte sequence
// - Big-endian mode ignores numeric flag
// - Swap bytes inside sixteen-bit words only
// - Force disabled: no force table access
// - Force enabled: two reads per word
// - Standard diagnosis: active line, disable supported
// - Extended diagnosis: both lines, no disable
`default_nettype none
module pdc_port_ctrl (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Telegram transfer events
	input wire pdc_pkg::pdc_xfer_s xfer,
	input wire logic [1:0] event_announce,
	input wire logic [1:0] event_param_set,
	// Queue levels
	input wire logic rx_queue_empty,
	input wire logic tx_queue0_empty,
	input wire logic tx_queue1_empty,
	output pdc_pkg::pdc_queue_e queue_sel,
	// Data word path
	input wire logic word_valid,
	input wire logic [15:0] word_in,
	output logic word_busy,
	output logic word_out_valid,
	output logic [15:0] word_out,
	// Force table reads
	output logic frc_rd,
	output logic frc_rd_data,
	input wire logic frc_ack,
	input wire logic [15:0] frc_rdata,
	// Line diagnosis
	input wire logic active_line_indicator,
	input wire logic [7:0] line_a_report,
	input wire logic [7:0] line_b_report,
	input wire logic ptd_request,
	output logic port_disabled,
	output logic compare_enable,
	// Interrupt
	output logic irq
);
	pdc_pkg::pdc_desc_s desc;
	logic [1:0] control;
	logic [1:0] event_announced;
	logic [1:0] event_parameter;
	logic [6:0] irq_status;
	logic [6:0] irq_mask;
	logic [15:0] report;
	logic ptd;
	pdc_pkg::pdc_word_e state;
	logic [15:0] word_hold;
	logic [15:0] force_mask;
	logic wr_pend;
	logic [7:0] wr_addr;
	logic rd_req;
	logic wr_req;
	logic [6:0] next_irq_set;
	logic xfer_good;
	logic queue_left;
	logic [15:0] swapped;
	logic [15:0] forced;

	// ---------------------------------------------
	// Helpers
	// ---------------------------------------------
	function automatic logic [6:0] irq_decode(input logic [2:0] sel, input logic is_sink);
		logic [6:0] r;
		r = 7'h00;
		if (sel != pdc_pkg::SEL_NONE) begin
			r[sel - 3'h1] = 1'b1;
		end
		if (sel == pdc_pkg::SEL_SEVEN && !is_sink) begin
			r = 7'h00;
		end
		return r;
	endfunction : irq_decode

	assign rd_req = hsel && hready && htrans[1] && !hwrite;
	assign wr_req = hsel && hready && htrans[1] && hwrite;
	assign xfer_good = xfer.done && (xfer.ok || (xfer.recoverable && desc.write_always));
	assign next_irq_set = xfer_good ? irq_decode(desc.interrupt_select, desc.sink) : 7'h00;
	// Decoded from the descriptor itself, not the registered queue choice
	assign queue_left = desc.sink ? !rx_queue_empty :
		desc.source_flag ? !(tx_queue0_empty && tx_queue1_empty) : 1'b0;
	assign swapped = (desc.numeric && !control[pdc_pkg::CTL_BIG_ENDIAN]) ?
		{word_hold[7:0], word_hold[15:8]} : word_hold;
	assign forced = (swapped & ~force_mask) | (frc_rdata & force_mask);

	// ---------------------------------------------
	// Bus response
	// ---------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b0;
			hresp <= 1'b0;
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend <= wr_req;
			if (wr_req) begin
				wr_addr <= haddr[7:0];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_req) begin
			case (haddr[7:0])
				pdc_pkg::OFS_DESCRIPTOR: hrdata <= {16'h0000, desc};
				pdc_pkg::OFS_CONTROL: hrdata <= {30'h0000_0000, control};
				pdc_pkg::OFS_EVENTS: hrdata <= {28'h000_0000, event_parameter, event_announced};
				pdc_pkg::OFS_IRQ_STATUS: hrdata <= {25'h000_0000, irq_status};
				pdc_pkg::OFS_IRQ_MASK: hrdata <= {25'h000_0000, irq_mask};
				pdc_pkg::OFS_REPORT: hrdata <= {16'h0000, report};
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// ---------------------------------------------
	// Software registers
	// ---------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			desc <= pdc_pkg::RST_DESCRIPTOR;
			control <= pdc_pkg::RST_CONTROL;
			irq_mask <= pdc_pkg::RST_IRQ_MASK;
		end else if (wr_pend) begin
			case (wr_addr)
				pdc_pkg::OFS_DESCRIPTOR: desc <= hwdata[15:0];
				pdc_pkg::OFS_CONTROL: control <= hwdata[1:0];
				pdc_pkg::OFS_IRQ_MASK: irq_mask <= hwdata[6:0];
				default: ;
			endcase
		end
	end

	// ---------------------------------------------
	// Pending events
	// ---------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			event_announced <= 2'h0;
			event_parameter <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (event_announce[i]) begin
					event_announced[i] <= 1'b1;
				end else if (xfer.done && desc.clear_pending_event[i] && !(desc.queue_attach && queue_left)) begin
					event_announced[i] <= 1'b0;
				end
				if (event_param_set[i]) begin
					event_parameter[i] <= 1'b1;
				end else if (xfer.done && desc.clear_pending_event[i]) begin
					event_parameter[i] <= 1'b0;
				end
			end
		end
	end

	// ---------------------------------------------
	// Interrupts
	// ---------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_status <= 7'h00;
		end else if (rd_req && haddr[7:0] == pdc_pkg::OFS_IRQ_STATUS) begin
			irq_status <= next_irq_set;
		end else begin
			irq_status <= irq_status | next_irq_set;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq <= 1'b0;
			compare_enable <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_mask);
			compare_enable <= (desc.interrupt_select == pdc_pkg::SEL_SEVEN) && desc.sink;
		end
	end

	// ---------------------------------------------
	// Queue selection
	// ---------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			queue_sel <= pdc_pkg::Q_AREA;
		end else if (!desc.queue_attach) begin
			queue_sel <= pdc_pkg::Q_AREA;
		end else if (desc.sink) begin
			queue_sel <= pdc_pkg::Q_RX;
		end else if (desc.source_flag) begin
			queue_sel <= !tx_queue0_empty ? pdc_pkg::Q_TX0 :
				(!tx_queue1_empty ? pdc_pkg::Q_TX1 : pdc_pkg::Q_TX0);
		end else begin
			queue_sel <= pdc_pkg::Q_AREA;
		end
	end

	// ---------------------------------------------
	// Word path with forcing
	// ---------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= pdc_pkg::W_IDLE;
			word_hold <= 16'h0000;
			force_mask <= 16'h0000;
			word_out <= 16'h0000;
			word_out_valid <= 1'b0;
			word_busy <= 1'b0;
			frc_rd <= 1'b0;
			frc_rd_data <= 1'b0;
		end else begin
			word_out_valid <= 1'b0;
			case (state)
				pdc_pkg::W_IDLE: begin
					if (word_valid) begin
						word_hold <= word_in;
						word_busy <= 1'b1;
						if (desc.force_enable) begin
							frc_rd <= 1'b1;
							frc_rd_data <= 1'b0;
							state <= pdc_pkg::W_MASK;
						end else begin
							force_mask <= 16'h0000;
							state <= pdc_pkg::W_EMIT;
						end
					end
				end
				pdc_pkg::W_MASK: begin
					if (frc_ack) begin
						force_mask <= frc_rdata;
						frc_rd_data <= 1'b1;
						state <= pdc_pkg::W_DATA;
					end
				end
				pdc_pkg::W_DATA: begin
					if (frc_ack) begin
						frc_rd <= 1'b0;
						frc_rd_data <= 1'b0;
						word_out <= forced;
						word_out_valid <= 1'b1;
						word_busy <= 1'b0;
						state <= pdc_pkg::W_IDLE;
					end
				end
				pdc_pkg::W_EMIT: begin
					word_out <= swapped;
					word_out_valid <= 1'b1;
					word_busy <= 1'b0;
					state <= pdc_pkg::W_IDLE;
				end
				default: state <= pdc_pkg::W_IDLE;
			endcase
		end
	end

	// ---------------------------------------------
	// Line diagnosis report
	// ---------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			report <= 16'h0000;
			ptd <= 1'b0;
			port_disabled <= 1'b0;
		end else begin
			if (xfer.done) begin
				if (control[pdc_pkg::CTL_EXT_DIAG]) begin
					report <= {line_b_report, line_a_report};
				end else begin
					report <= {8'h00, active_line_indicator ? line_b_report : line_a_report};
				end
				ptd <= ptd_request && !control[pdc_pkg::CTL_EXT_DIAG];
			end
			port_disabled <= ptd && !control[pdc_pkg::CTL_EXT_DIAG];
		end
	end

endmodule : pdc_port_ctrl
`default_nettype wire

// File: pdc_port_ctrl_chk.sv
// Purpose: Port checks for the descriptor block
// Assumes: One clock, async low reset
// Notes: Bound from the bench file
`default_nettype none
module pdc_chk (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Watched ports
	input wire pdc_pkg::pdc_xfer_s xfer,
	input wire logic word_valid,
	input wire logic word_busy,
	input wire logic word_out_valid,
	input wire logic frc_rd,
	input wire logic frc_rd_data,
	input wire logic frc_ack,
	input wire logic irq,
	input wire logic port_disabled
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_plain_pace: assert property (word_valid && !word_busy && !word_out_valid ##1 !frc_rd |=> word_out_valid)
		else $error("late word");
	a_idle_no_read: assert property (!word_busy |-> !frc_rd)
		else $error("stray read");
	a_mask_first: assert property ($rose(frc_rd) |-> !frc_rd_data)
		else $error("mask not first");
	a_data_next: assert property (frc_rd && !frc_rd_data && frc_ack |=> frc_rd && frc_rd_data)
		else $error("no data read");
	a_forced_out: assert property (frc_rd && frc_rd_data && frc_ack |=> !frc_rd && word_out_valid)
		else $error("late forced word");
	a_take_busy: assert property (word_valid && !word_busy && !word_out_valid |=> word_busy)
		else $error("word dropped");
	a_error_quiet: assert property (!irq && xfer.done && !xfer.ok && !xfer.recoverable |=> !irq [*2])
		else $error("irq on error");
	a_disable_at_xfer: assert property ($rose(port_disabled) |-> $past(xfer.done, 2))
		else $error("stray disable");
	c_forced: cover property (frc_rd && frc_rd_data && frc_ack);
	c_irq: cover property ($rose(irq));
	c_off: cover property ($rose(port_disabled));
endmodule : pdc_chk
`default_nettype wire

// File: pdc_mem_model.sv
// Purpose: Force table memory for the word path
// Assumes: A read is held until answered
// Notes: Bus floats to a changing value when idle
`default_nettype none
module pdc_mem_model (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Settings
	input wire logic [3:0] delay,
	input wire logic [15:0] mask,
	input wire logic [15:0] fdata,
	// Read port
	input wire logic frc_rd,
	input wire logic frc_rd_data,
	output logic frc_ack,
	output logic [15:0] frc_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			frc_ack <= 1'b0;
			cnt <= 4'h0;
			frc_rdata <= 16'h5a5a;
		end else if (frc_rd && !frc_ack && cnt == delay) begin
			frc_ack <= 1'b1;
			cnt <= 4'h0;
			frc_rdata <= frc_rd_data ? fdata : mask;
		end else begin
			frc_ack <= 1'b0;
			cnt <= (frc_rd && !frc_ack) ? cnt + 4'h1 : 4'h0;
			frc_rdata <= ~frc_rdata;
		end
	end
endmodule : pdc_mem_model
`default_nettype wire

// File: pdc_port_ctrl_bench.sv
// Purpose: Self-checking bench for pdc_port_ctrl
// Assumes: Zero-wait AHB-Lite slave
// Notes: Memory model answers force reads
`default_nettype none
module pdc_port_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, word_valid = 1'b0, ptd_request = 1'b0;
	logic rx_queue_empty = 1'b1, tx_queue0_empty = 1'b1, tx_queue1_empty = 1'b0, active_line_indicator = 1'b1;
	logic [1:0] htrans = 2'h0, event_announce = 2'h0, event_param_set = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [3:0] delay = 4'h3;
	logic [7:0] line_a_report = 8'h11, line_b_report = 8'h22;
	logic [15:0] word_in = 16'h0, mask = 16'h00ff, fdata = 16'habcd;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
	logic [31:0] hrdata;
	logic [15:0] word_out, frc_rdata;
	logic hreadyout, hresp, word_busy, word_out_valid, frc_rd, frc_rd_data, frc_ack, port_disabled, compare_enable, irq;
	pdc_pkg::pdc_xfer_s xfer = 3'h0;
	pdc_pkg::pdc_queue_e queue_sel;
	int err_total = 0, cmp_count = 0, ack_count = 0;
	pdc_port_ctrl uut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.xfer(xfer), .event_announce(event_announce), .event_param_set(event_param_set),
		.rx_queue_empty(rx_queue_empty), .tx_queue0_empty(tx_queue0_empty), .tx_queue1_empty(tx_queue1_empty),
		.queue_sel(queue_sel), .word_valid(word_valid), .word_in(word_in), .word_busy(word_busy),
		.word_out_valid(word_out_valid), .word_out(word_out), .frc_rd(frc_rd), .frc_rd_data(frc_rd_data),
		.frc_ack(frc_ack), .frc_rdata(frc_rdata), .active_line_indicator(active_line_indicator),
		.line_a_report(line_a_report), .line_b_report(line_b_report), .ptd_request(ptd_request),
		.port_disabled(port_disabled), .compare_enable(compare_enable), .irq(irq)
	);
	pdc_mem_model mem (
		.hclk(hclk), .hresetn(hresetn), .delay(delay), .mask(mask), .fdata(fdata),
		.frc_rd(frc_rd), .frc_rd_data(frc_rd_data), .frc_ack(frc_ack), .frc_rdata(frc_rdata)
	);
	always #12.5 hclk = ~hclk;
	// Force table answers seen
	always @(posedge hclk) begin
		if (frc_ack === 1'b1) begin
			ack_count <= ack_count + 1;
		end
	end
	task automatic tally_and_finish;
		$display("compares %0d errors %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
	endtask : tick
	task automatic await(ref logic s);
		int i;
		i = 0;
		@(posedge hclk);
		while (s !== 1'b1) begin
			i++;
			if (i > 64) begin
				err_total++;
				tally_and_finish;
			end
			@(posedge hclk);
		end
	endtask : await
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		await(hreadyout);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		await(hreadyout);
		q = hrdata;
	endtask : bus
	// Transfer, then check irq and one register
	task automatic xc(input logic [15:0] dsc, input logic [1:0] okr, input logic [7:0] a, input logic [31:0] e,
		input logic ei);
		bus(1'b1, pdc_pkg::OFS_DESCRIPTOR, {16'h0, dsc});
		xfer <= {1'b1, okr};
		tick(1);
		xfer <= 3'h0;
		tick(3);
		chk(irq, ei);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask : xc
	task automatic wd(input logic [15:0] d, input logic [15:0] e);
		word_valid <= 1'b1;
		word_in <= d;
		tick(1);
		word_valid <= 1'b0;
		await(word_out_valid);
		chk(word_out, e);
		tick(1);
	endtask : wd
	initial begin
		tick(20);
		hresetn <= 1'b1;
		tick(2);
		bus(1'b1, pdc_pkg::OFS_IRQ_MASK, 32'h7f);
		for (int s = 0; s < 8; s++) begin
			xc(16'h0100 | 16'(s), 2'b10, pdc_pkg::OFS_IRQ_STATUS, s == 0 ? 0 : 32'h1 << (s - 1), s != 0);
		end
		chk(compare_enable, 1'b1);
		xc(16'h0207, 2'b10, pdc_pkg::OFS_IRQ_STATUS, 32'h0, 1'b0);
		chk(compare_enable, 1'b0);
		xc(16'h0101, 2'b00, pdc_pkg::OFS_IRQ_STATUS, 32'h0, 1'b0);
		xc(16'h0101, 2'b01, pdc_pkg::OFS_IRQ_STATUS, 32'h0, 1'b0);
		xc(16'h0501, 2'b01, pdc_pkg::OFS_IRQ_STATUS, 32'h1, 1'b1);
		bus(1'b1, pdc_pkg::OFS_IRQ_MASK, 32'h0);
		xc(16'h0102, 2'b10, pdc_pkg::OFS_IRQ_STATUS, 32'h2, 1'b0);
		event_announce <= 2'h3;
		event_param_set <= 2'h3;
		tick(1);
		event_announce <= 2'h0;
		event_param_set <= 2'h0;
		xc(16'h0140, 2'b00, pdc_pkg::OFS_EVENTS, 32'ha, 1'b0);
		rx_queue_empty <= 1'b0;
		xc(16'h01a0, 2'b10, pdc_pkg::OFS_EVENTS, 32'h2, 1'b0);
		chk(queue_sel, pdc_pkg::Q_RX);
		rx_queue_empty <= 1'b1;
		xc(16'h01a0, 2'b10, pdc_pkg::OFS_EVENTS, 32'h0, 1'b0);
		xc(16'h0220, 2'b10, pdc_pkg::OFS_EVENTS, 32'h0, 1'b0);
		chk(queue_sel, pdc_pkg::Q_TX1);
		tx_queue0_empty <= 1'b0;
		tick(2);
		chk(queue_sel, pdc_pkg::Q_TX0);
		tx_queue0_empty <= 1'b1;
		xc(16'h0000, 2'b10, pdc_pkg::OFS_REPORT, 32'h22, 1'b0);
		chk(queue_sel, pdc_pkg::Q_AREA);
		wd(16'h1234, 16'h1234);
		bus(1'b1, pdc_pkg::OFS_DESCRIPTOR, 32'h10);
		wd(16'h1234, 16'h3412);
		bus(1'b1, pdc_pkg::OFS_CONTROL, 32'h1);
		wd(16'h1234, 16'h1234);
		chk(ack_count, 0);
		bus(1'b1, pdc_pkg::OFS_CONTROL, 32'h0);
		bus(1'b1, pdc_pkg::OFS_DESCRIPTOR, 32'h18);
		wd(16'h1234, 16'h34cd);
		delay <= 4'h0;
		wd(16'h5678, 16'h78cd);
		chk(ack_count, 4);
		ptd_request <= 1'b1;
		xc(16'h0100, 2'b10, pdc_pkg::OFS_REPORT, 32'h22, 1'b0);
		chk(port_disabled, 1'b1);
		bus(1'b1, pdc_pkg::OFS_CONTROL, 32'h2);
		xc(16'h0100, 2'b10, pdc_pkg::OFS_REPORT, 32'h2211, 1'b0);
		chk(port_disabled, 1'b0);
		chk(hresp, 1'b0);
		tally_and_finish;
	end
endmodule : pdc_port_ctrl_bench
bind pdc_port_ctrl pdc_chk chk_i (
	.hclk(hclk), .hresetn(hresetn), .xfer(xfer), .word_valid(word_valid), .word_busy(word_busy),
	.word_out_valid(word_out_valid), .frc_rd(frc_rd), .frc_rd_data(frc_rd_data), .frc_ack(frc_ack),
	.irq(irq), .port_disabled(port_disabled)
);
`default_nettype wire
